// [hdl/eeprom_rst_pkg.sv]
// constants, field layouts and carrier types for the eeprom reset and default-state block
// assumes a single 25 MHz clock and a plain address/strobe register port
package eeprom_rst_pkg;

	localparam int CLK_HZ          = 25_000_000;
	localparam int WRITE_CYCLE_MS  = 4;
	// longest time: rounds down to whole cycles
	localparam int WRITE_CYCLE_CLKS = (CLK_HZ / 1000) * WRITE_CYCLE_MS;

	localparam logic [7:0] SOFT_RESET_OPCODE = 8'h7c;
	localparam logic [3:0] OPCODE_BITS       = 4'h8;
	localparam logic [7:0] ERASED_BYTE       = 8'hff;
	localparam int         SERIAL_BYTES      = 16;
	localparam int         ID_PAGE_BYTES     = 32;
	localparam int         PARTITION_COUNT   = 4;

	// register offsets on the software port
	localparam logic [6:0] OFS_STATUS0   = 7'h00;
	localparam logic [6:0] OFS_STATUS1   = 7'h01;
	localparam logic [6:0] OFS_PART0     = 7'h02;
	localparam logic [6:0] OFS_UNDERVOLTAGE_LOCKOUT      = 7'h06;
	localparam logic [6:0] OFS_CONTROL   = 7'h07;
	localparam logic [6:0] OFS_SECURITY  = 7'h40;

	// status byte 0 fields
	localparam int S0_PROTECT_EN = 7;
	localparam int S0_BP_HI      = 3;
	localparam int S0_BP_LO      = 2;
	localparam int S0_WEL        = 1;
	localparam int S0_BUSY       = 0;
	// status byte 1 fields
	localparam int S1_MODE_SEL   = 7;
	localparam int S1_ECS        = 6;
	localparam int S1_FREEZE     = 5;
	localparam int S1_PARTITION_WRITE_ENABLE_LATCH       = 4;
	localparam int S1_BOUNDARY   = 3;
	localparam int S1_WLS        = 2;
	localparam int S1_BUSY       = 0;
	// partition register: behaviour bits above, endpoint below
	localparam int PART_END_HI   = 4;
	// control register fields
	localparam int CT_UNPROT     = 0;
	localparam int CT_SOFT_RESET_INSTR_SEEN  = 1;

	localparam logic [7:0] STATUS_RESET    = 8'h00;
	localparam logic [7:0] PARTITION_RESET = 8'h00;
	localparam logic [5:0] UNDERVOLTAGE_LOCKOUT_RESET      = 6'h00;

	typedef struct packed {
		logic cs_b;
		logic sck;
		logic si;
	} spi_pins_t;

	typedef struct packed {
		logic write_enable_latch;
		logic error_correct_state;
		logic partition_write_enable_latch;
		logic write_lockout_state;
	} volatile_bits_t;

	localparam volatile_bits_t VOLATILE_RESET = '0;

	typedef enum logic [2:0] {
		LINK_STANDBY = 3'b001,
		LINK_ACTIVE  = 3'b010,
		LINK_WAIT_HI = 3'b100
	} link_state_t;

endpackage : eeprom_rst_pkg

// [hdl/pin_sync.sv]
// two-flop synchroniser for a group of asynchronous pins
// assumes the pins have no timing relation to clk_i
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_ff;

	for (genvar g = 0; g < WIDTH; g++) begin : g_bit
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				// reset low: a select already low at release never looks like a fresh fall
				meta_ff[g] <= 1'b0;
				sync_o[g]  <= 1'b0;
			end else begin
				meta_ff[g] <= async_i[g];
				sync_o[g]  <= meta_ff[g];
			end
		end
	end

endmodule : pin_sync

// [hdl/write_cycle_timer.sv]
// self-timed internal write cycle: busy from start until the cycle count runs out
// assumes start_i is a one-cycle pulse on clk_i
module write_cycle_timer #(
	parameter int CYCLES = eeprom_rst_pkg::WRITE_CYCLE_CLKS
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_ff;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_ff <= '0;
			busy_o   <= 1'b0;
			done_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				count_ff <= CW'(CYCLES - 1);
				busy_o   <= 1'b1;
			end else if (busy_o) begin
				if (count_ff == '0) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					count_ff <= count_ff - 1'b1;
				end
			end
		end
	end

endmodule : write_cycle_timer

// [hdl/eeprom_reset_default_state.sv]
// reset, soft reset, write-cycle window and default register state of a serial eeprom
// assumes chip select, serial clock and serial data arrive asynchronously from an spi host;
// rst_b_i comes from the power-on detector; write_seq_valid_i comes from the instruction
// decoder on clk_i and is high while a complete valid write sequence has been shifted in

module eeprom_reset_default_state #(
	parameter int           WRITE_CYCLES  = eeprom_rst_pkg::WRITE_CYCLE_CLKS,
	// arbitrary value standing in for the factory serial number
	parameter logic [127:0] SERIAL_NUMBER = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_b_i,
	input  wire eeprom_rst_pkg::spi_pins_t spi_i,
	input  wire logic                      write_seq_valid_i,
	input  wire logic                      ecc_event_i,
	input  wire logic                      lockout_event_i,
	input  wire logic [6:0]                addr_i,
	input  wire logic [7:0]                wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [7:0]                rdata_o,
	output logic                           busy_o,
	output logic                           soft_reset_o,
	output logic                           array_unprotected_o,
	output logic                           instr_accept_o
);

	eeprom_rst_pkg::spi_pins_t      pins_sync;
	logic                           cs_b_q_ff;
	logic                           sck_q_ff;
	logic                           cs_fall;
	logic                           cs_rise;
	logic                           sck_rise;
	eeprom_rst_pkg::link_state_t    state_ff;
	eeprom_rst_pkg::link_state_t    nxt_state;
	logic [7:0]                     shift_ff;
	logic [3:0]                     bit_count_ff;
	logic                           overrun_ff;
	logic                           soft_reset_instr_valid;
	logic                           write_start;
	logic                           write_done;
	logic                           soft_reset_ff;
	logic                           soft_reset_instr_seen_ff;
	eeprom_rst_pkg::volatile_bits_t vol_ff;
	logic                           protect_en_ff;
	logic [1:0]                     block_protect_ff;
	logic                           mode_sel_ff;
	logic                           freeze_ff;
	logic                           boundary_ff;
	logic [7:0]                     part_ff [eeprom_rst_pkg::PARTITION_COUNT];
	logic [5:0]                     undervoltage_lockout_ff;
	logic [7:0]                     status0;
	logic [7:0]                     status1;
	logic [7:0]                     control;
	logic [7:0]                     security_byte;
	logic [6:0]                     sec_index;
	logic                           partitions_clear;
	logic                           wr_status0;
	logic                           wr_status1;
	logic                           wr_undervoltage_lockout;
	logic [7:0]                     nxt_rdata;

	// pins pass two flops before any logic looks at them
	pin_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.async_i (spi_i),
		.sync_o  (pins_sync)
	);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// matches the synchroniser's reset view so no false fall follows release
			cs_b_q_ff <= 1'b0;
			sck_q_ff  <= 1'b0;
		end else begin
			cs_b_q_ff <= pins_sync.cs_b;
			sck_q_ff  <= pins_sync.sck;
		end
	end

	assign cs_fall  = cs_b_q_ff && !pins_sync.cs_b;
	assign cs_rise  = !cs_b_q_ff && pins_sync.cs_b;
	assign sck_rise = !sck_q_ff && pins_sync.sck;

	// link state: a select already low at reset release is not a valid start
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			eeprom_rst_pkg::LINK_STANDBY: begin
				if (cs_fall) begin
					nxt_state = eeprom_rst_pkg::LINK_ACTIVE;
				end else if (!pins_sync.cs_b) begin
					nxt_state = eeprom_rst_pkg::LINK_WAIT_HI;
				end
			end
			eeprom_rst_pkg::LINK_ACTIVE: begin
				if (cs_rise) begin
					nxt_state = eeprom_rst_pkg::LINK_STANDBY;
				end
			end
			eeprom_rst_pkg::LINK_WAIT_HI: begin
				if (pins_sync.cs_b) begin
					nxt_state = eeprom_rst_pkg::LINK_STANDBY;
				end
			end
			default: nxt_state = eeprom_rst_pkg::LINK_STANDBY;
		endcase
	end

	// power-on reset holds the link in standby and drops everything shifted
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= eeprom_rst_pkg::LINK_STANDBY;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign instr_accept_o = (state_ff == eeprom_rst_pkg::LINK_ACTIVE);

	// opcode capture on serial clock rising edges while selected
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_ff     <= 8'h00;
			bit_count_ff <= 4'h0;
			overrun_ff   <= 1'b0;
		end else if (cs_fall) begin
			shift_ff     <= 8'h00;
			bit_count_ff <= 4'h0;
			overrun_ff   <= 1'b0;
		end else if (instr_accept_o && sck_rise) begin
			if (bit_count_ff < eeprom_rst_pkg::OPCODE_BITS) begin
				shift_ff     <= {shift_ff[6:0], pins_sync.si};
				bit_count_ff <= bit_count_ff + 4'h1;
			end else begin
				overrun_ff <= 1'b1;
			end
		end
	end

	// exactly eight bits of the reset opcode, then deselect, and not busy
	assign soft_reset_instr_valid = instr_accept_o && cs_rise && !busy_o
		&& (bit_count_ff == eeprom_rst_pkg::OPCODE_BITS) && !overrun_ff
		&& (shift_ff == eeprom_rst_pkg::SOFT_RESET_OPCODE);

	// a write sequence only launches on its own deselect edge
	assign write_start = instr_accept_o && cs_rise && write_seq_valid_i && !busy_o;

	write_cycle_timer #(
		.CYCLES (WRITE_CYCLES)
	) u_write_cycle_timer (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.start_i (write_start),
		.busy_o  (busy_o),
		.done_o  (write_done)
	);

	// reset acts one clock after the deselect edge is seen, well inside the deselect time
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			soft_reset_ff <= 1'b0;
			soft_reset_instr_seen_ff  <= 1'b0;
		end else begin
			soft_reset_ff <= soft_reset_instr_valid;
			if (soft_reset_instr_valid) begin
				soft_reset_instr_seen_ff <= 1'b1;
			end else if (wr_i && (addr_i == eeprom_rst_pkg::OFS_CONTROL)
				&& wdata_i[eeprom_rst_pkg::CT_SOFT_RESET_INSTR_SEEN]) begin
				soft_reset_instr_seen_ff <= 1'b0;
			end
		end
	end

	assign soft_reset_o = soft_reset_ff;

	assign wr_status0 = wr_i && (addr_i == eeprom_rst_pkg::OFS_STATUS0) && !busy_o;
	assign wr_status1 = wr_i && (addr_i == eeprom_rst_pkg::OFS_STATUS1) && !busy_o;
	assign wr_undervoltage_lockout    = wr_i && (addr_i == eeprom_rst_pkg::OFS_UNDERVOLTAGE_LOCKOUT) && !busy_o;

	// volatile latches: power-up and soft reset clear them, hardware events win over clears
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vol_ff <= eeprom_rst_pkg::VOLATILE_RESET;
		end else begin
			if (soft_reset_ff || write_done) begin
				vol_ff.write_enable_latch <= 1'b0;
			end else if (wr_status0) begin
				vol_ff.write_enable_latch <= wdata_i[eeprom_rst_pkg::S0_WEL];
			end
			if (ecc_event_i) begin
				vol_ff.error_correct_state <= 1'b1;
			end else if (soft_reset_ff) begin
				vol_ff.error_correct_state <= 1'b0;
			end else if (wr_status1) begin
				vol_ff.error_correct_state <= wdata_i[eeprom_rst_pkg::S1_ECS];
			end
			if (lockout_event_i) begin
				vol_ff.write_lockout_state <= 1'b1;
			end else if (soft_reset_ff) begin
				vol_ff.write_lockout_state <= 1'b0;
			end else if (wr_status1) begin
				vol_ff.write_lockout_state <= wdata_i[eeprom_rst_pkg::S1_WLS];
			end
			if (soft_reset_ff) begin
				vol_ff.partition_write_enable_latch <= 1'b0;
			end else if (wr_status1) begin
				vol_ff.partition_write_enable_latch <= wdata_i[eeprom_rst_pkg::S1_PARTITION_WRITE_ENABLE_LATCH];
			end
		end
	end

	// nonvolatile status bits, factory default zero; soft reset leaves them alone
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			protect_en_ff    <= 1'b0;
			block_protect_ff <= 2'b00;
		end else if (wr_status0 && !protect_en_ff) begin
			protect_en_ff    <= wdata_i[eeprom_rst_pkg::S0_PROTECT_EN];
			block_protect_ff <= wdata_i[eeprom_rst_pkg::S0_BP_HI:eeprom_rst_pkg::S0_BP_LO];
		end
	end

	// freeze is one-way: once set only power-up clears it here
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_sel_ff <= 1'b0;
			freeze_ff   <= 1'b0;
			boundary_ff <= 1'b0;
		end else if (wr_status1 && !freeze_ff) begin
			mode_sel_ff <= wdata_i[eeprom_rst_pkg::S1_MODE_SEL];
			freeze_ff   <= wdata_i[eeprom_rst_pkg::S1_FREEZE];
			boundary_ff <= wdata_i[eeprom_rst_pkg::S1_BOUNDARY];
		end
	end

	// partition registers, one per entry
	for (genvar p = 0; p < eeprom_rst_pkg::PARTITION_COUNT; p++) begin : g_part
		logic wr_part;
		assign wr_part = wr_i && !busy_o && !freeze_ff
			&& (addr_i == eeprom_rst_pkg::OFS_PART0 + 7'(p));
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				part_ff[p] <= eeprom_rst_pkg::PARTITION_RESET;
			end else if (wr_part) begin
				part_ff[p][7:eeprom_rst_pkg::PART_END_HI+1] <=
					wdata_i[7:eeprom_rst_pkg::PART_END_HI+1];
				if (!boundary_ff) begin
					part_ff[p][eeprom_rst_pkg::PART_END_HI:0] <=
						wdata_i[eeprom_rst_pkg::PART_END_HI:0];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			undervoltage_lockout_ff <= eeprom_rst_pkg::UNDERVOLTAGE_LOCKOUT_RESET;
		end else if (wr_undervoltage_lockout) begin
			undervoltage_lockout_ff <= wdata_i[5:0];
		end
	end

	// partitions of 00h carry no protection, so the whole array stays writable
	assign partitions_clear = (part_ff[0] == eeprom_rst_pkg::PARTITION_RESET)
		&& (part_ff[1] == eeprom_rst_pkg::PARTITION_RESET)
		&& (part_ff[2] == eeprom_rst_pkg::PARTITION_RESET)
		&& (part_ff[3] == eeprom_rst_pkg::PARTITION_RESET);

	// coarse view only: a nonzero setting of the selected scheme (partitions or block protect) counts as protected
	assign array_unprotected_o = mode_sel_ff ? partitions_clear
		: (block_protect_ff == 2'b00);

	always_comb begin
		status0 = eeprom_rst_pkg::STATUS_RESET;
		status0[eeprom_rst_pkg::S0_PROTECT_EN]                          = protect_en_ff;
		status0[eeprom_rst_pkg::S0_BP_HI:eeprom_rst_pkg::S0_BP_LO]      = block_protect_ff;
		status0[eeprom_rst_pkg::S0_WEL]                                 = vol_ff.write_enable_latch;
		status0[eeprom_rst_pkg::S0_BUSY]                                = busy_o;
	end

	always_comb begin
		status1 = eeprom_rst_pkg::STATUS_RESET;
		status1[eeprom_rst_pkg::S1_MODE_SEL] = mode_sel_ff;
		status1[eeprom_rst_pkg::S1_ECS]      = vol_ff.error_correct_state;
		status1[eeprom_rst_pkg::S1_FREEZE]   = freeze_ff;
		status1[eeprom_rst_pkg::S1_PARTITION_WRITE_ENABLE_LATCH]     = vol_ff.partition_write_enable_latch;
		status1[eeprom_rst_pkg::S1_BOUNDARY] = boundary_ff;
		status1[eeprom_rst_pkg::S1_WLS]      = vol_ff.write_lockout_state;
		status1[eeprom_rst_pkg::S1_BUSY]     = busy_o;
	end

	always_comb begin
		control = 8'h00;
		control[eeprom_rst_pkg::CT_UNPROT]    = array_unprotected_o;
		control[eeprom_rst_pkg::CT_SOFT_RESET_INSTR_SEEN] = soft_reset_instr_seen_ff;
	end

	// security window: serial number low bytes, erased id page above
	assign sec_index = addr_i - eeprom_rst_pkg::OFS_SECURITY;

	always_comb begin
		security_byte = eeprom_rst_pkg::ERASED_BYTE;
		if (sec_index < 7'(eeprom_rst_pkg::SERIAL_BYTES)) begin
			security_byte = SERIAL_NUMBER[sec_index[3:0]*8 +: 8];
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		if (addr_i == eeprom_rst_pkg::OFS_STATUS0) begin
			nxt_rdata = status0;
		end else if (addr_i == eeprom_rst_pkg::OFS_STATUS1) begin
			nxt_rdata = status1;
		end else if ((addr_i >= eeprom_rst_pkg::OFS_PART0)
			&& (addr_i < eeprom_rst_pkg::OFS_UNDERVOLTAGE_LOCKOUT)) begin
			nxt_rdata = part_ff[2'(addr_i - eeprom_rst_pkg::OFS_PART0)];
		end else if (addr_i == eeprom_rst_pkg::OFS_UNDERVOLTAGE_LOCKOUT) begin
			nxt_rdata = {2'b00, undervoltage_lockout_ff};
		end else if (addr_i == eeprom_rst_pkg::OFS_CONTROL) begin
			nxt_rdata = control;
		end else if ((addr_i >= eeprom_rst_pkg::OFS_SECURITY)
			&& (sec_index < 7'(eeprom_rst_pkg::SERIAL_BYTES + eeprom_rst_pkg::ID_PAGE_BYTES))) begin
			nxt_rdata = security_byte;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= nxt_rdata;
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule : eeprom_reset_default_state

// [verification/eeprom_reset_default_state_chk.sv]
// checker: port timing of the reset and default-state block
// assumes one clock domain and the bind at the foot of this file
module eeprom_reset_default_state_chk #(
	parameter int WRITE_CYCLES = 20
) (
	input wire logic                      clk_i,
	input wire logic                      rst_b_i,
	input wire eeprom_rst_pkg::spi_pins_t spi_i,
	input wire logic                      write_seq_valid_i,
	input wire logic [6:0]                addr_i,
	input wire logic                      rd_i,
	input wire logic [7:0]                rdata_o,
	input wire logic                      busy_o,
	input wire logic                      soft_reset_o,
	input wire logic                      instr_accept_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cs_high_run_ff;
	int         busy_run_ff;
	// saturates so a long idle gap cannot wrap back into the window
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) cs_high_run_ff <= 4'h0;
		else if (!spi_i.cs_b) cs_high_run_ff <= 4'h0;
		else if (cs_high_run_ff != 4'hf) cs_high_run_ff <= cs_high_run_ff + 4'h1;
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) busy_run_ff <= 0;
		else busy_run_ff <= busy_o ? busy_run_ff + 1 : 0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_busy_len; $fell(busy_o) |-> busy_run_ff == WRITE_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_busy_start;
		$rose(busy_o) |-> cs_high_run_ff inside {[4'h3:4'h6]} && $past(write_seq_valid_i);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy start");
	property p_soft_reset_instr_cs; soft_reset_o |-> cs_high_run_ff inside {[4'h3:4'h6]}; endproperty
	a_soft_reset_instr_cs: assert property (p_soft_reset_instr_cs) else $error("soft reset timing");
	property p_soft_reset_instr_one; soft_reset_o |=> !soft_reset_o; endproperty
	a_soft_reset_instr_one: assert property (p_soft_reset_instr_one) else $error("soft reset width");
	property p_soft_reset_instr_idle; soft_reset_o |-> !$past(busy_o); endproperty
	a_soft_reset_instr_idle: assert property (p_soft_reset_instr_idle) else $error("soft reset while busy");
	property p_accept_cs; instr_accept_o |-> cs_high_run_ff < 4'h5; endproperty
	a_accept_cs: assert property (p_accept_cs) else $error("accept unselected");
	property p_accept_fall; $rose(instr_accept_o) |-> $past(spi_i.cs_b, 4) && !spi_i.cs_b; endproperty
	a_accept_fall: assert property (p_accept_fall) else $error("accept without fall");
	property p_rdy; rd_i && addr_i == 7'h00 |=> rdata_o[0] == $past(busy_o); endproperty
	a_rdy: assert property (p_rdy) else $error("ready bit");
	property p_rsvd; rd_i && addr_i == 7'h00 |=> rdata_o[6:4] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits");
	property p_rst_quiet;
		$rose(rst_b_i) |-> !busy_o && !soft_reset_o && !instr_accept_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("not idle after reset");
	c_soft_reset_instr: cover property (soft_reset_o);
	c_busy: cover property ($fell(busy_o));
	c_accept: cover property ($rose(instr_accept_o));
endmodule : eeprom_reset_default_state_chk

bind eeprom_reset_default_state eeprom_reset_default_state_chk #(
	.WRITE_CYCLES(WRITE_CYCLES)
) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .spi_i(spi_i),
	.write_seq_valid_i(write_seq_valid_i), .addr_i(addr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .busy_o(busy_o), .soft_reset_o(soft_reset_o),
	.instr_accept_o(instr_accept_o));

// [verification/spi_host_model.sv]
// spi host model: frames of up to 16 bits, msb first, sck period 8 clocks
// assumes it is driven from the bench clock; sck stands low between frames
module spi_host_model (
	input  wire logic                 clk_i,
	output eeprom_rst_pkg::spi_pins_t spi_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic first_sel = 1'b1;
	initial spi_o = '{cs_b: 1'b1, sck: 1'b0, si: 1'b0};
	task automatic frame(input logic [15:0] bits, input int n);
		if (first_sel) begin
			repeat (2500) @(posedge clk_i);
			first_sel = 1'b0;
		end
		@(posedge clk_i) spi_o.cs_b <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			spi_o.si <= bits[i];
			repeat (4) @(posedge clk_i);
			spi_o.sck <= 1'b1;
			repeat (4) @(posedge clk_i);
			spi_o.sck <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		spi_o.cs_b <= 1'b1;
		// released data line must not keep looking valid
		spi_o.si <= ~spi_o.si;
		repeat (8) @(posedge clk_i);
	endtask : frame
endmodule : spi_host_model

// [verification/eeprom_reset_default_state_tb.sv]
// testbench: defaults, register port, soft reset and write-cycle window
// assumes the host model and the checker bind are compiled with the design
module eeprom_reset_default_state_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WC = 300;
	// arbitrary stand-in serial number
	localparam logic [127:0] SN = 128'h5a5a_1234_0f0f_beef_c3c3_7788_9911_2468;
	logic       clk_i = 1'b0, rst_b_i = 1'b0, wsv_i = 1'b0, ecc_i = 1'b0, lock_i = 1'b0;
	logic       wr_i = 1'b0, rd_i = 1'b0, busy_o, soft_reset_instr_o, unprot_o, accept_o;
	logic [6:0] addr_i = 7'h00;
	logic [7:0] wdata_i = 8'h00, rdata_o, v;
	int         err_count = 0, check_count = 0, seed = 60, soft_reset_instr_n = 0, acc_n = 0, a0;
	eeprom_rst_pkg::spi_pins_t spi;
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (soft_reset_instr_o === 1'b1) soft_reset_instr_n++;
		if (accept_o === 1'b1) acc_n++;
	end
	spi_host_model u_host (.clk_i(clk_i), .spi_o(spi));
	eeprom_reset_default_state #(.WRITE_CYCLES(WC), .SERIAL_NUMBER(SN)) u_dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .spi_i(spi), .write_seq_valid_i(wsv_i),
		.ecc_event_i(ecc_i), .lockout_event_i(lock_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.busy_o(busy_o), .soft_reset_o(soft_reset_instr_o), .array_unprotected_o(unprot_o),
		.instr_accept_o(accept_o));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk8
	task automatic chk1(input string n, input logic e, input logic s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %b got %b", n, e, s);
		end
	endtask : chk1
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i) wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	// mask hides bits that no rule fixes in that case
	task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i) rd_i <= 1'b0;
		#1 chk8("rdata", e & m, rdata_o & m);
		@(posedge clk_i);
	endtask : rd
	task automatic wait_busy(input logic lvl);
		int i;
		for (i = 0; i < 2 * WC && busy_o !== lvl; i++) @(posedge clk_i) #1;
		if (i == 2 * WC) begin
			err_count++;
			give_verdict();
		end
		@(posedge clk_i);
	endtask : wait_busy
	initial begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		chk1("unprot", 1'b1, unprot_o);
		for (int a = 0; a < 8; a++) rd(7'(a), (a == 7) ? 8'h01 : 8'h00);
		for (int a = 0; a < 48; a++) rd(7'(a + 64), (a < 16) ? SN[8*a +: 8] : 8'hff);
		rd(7'h7f, 8'h00);
		$display("test defaults done");
		for (int k = 0; k < 5; k++) begin
			v = (k == 0) ? 8'h00 : 8'($random(seed)) & 8'h0e;
			wr(7'h00, v);
			rd(7'h00, v);
			chk1("unprot", v[3:2] == 2'b00, unprot_o);
		end
		wr(7'h00, 8'h02);
		v = 8'($random(seed)) | 8'h01;
		wr(7'h03, v);
		rd(7'h03, v);
		wr(7'h01, 8'h80);
		chk1("unprot", 1'b0, unprot_o);
		wr(7'h01, 8'h00);
		chk1("unprot", 1'b1, unprot_o);
		$display("test registers done");
		wr(7'h00, 8'h06);
		wr(7'h01, 8'h10);
		ecc_i <= 1'b1;
		lock_i <= 1'b1;
		@(posedge clk_i) ecc_i <= 1'b0;
		lock_i <= 1'b0;
		wr(7'h06, 8'h2a);
		rd(7'h01, 8'h54);
		u_host.frame(16'h007c, 8);
		chk1("soft_reset_instr", 1'b1, soft_reset_instr_n == 1);
		chk1("accept", 1'b1, acc_n > 0);
		rd(7'h00, 8'h04);
		rd(7'h01, 8'h00);
		rd(7'h06, 8'h2a);
		rd(7'h03, v);
		rd(7'h07, 8'h02);
		wr(7'h07, 8'h02);
		rd(7'h07, 8'h00);
		u_host.frame(16'h00f9, 9);
		chk1("soft_reset_instr", 1'b1, soft_reset_instr_n == 1);
		$display("test soft reset done");
		wr(7'h00, 8'h06);
		wsv_i <= 1'b1;
		u_host.frame(16'h0002, 8);
		wait_busy(1'b1);
		wsv_i <= 1'b0;
		rd(7'h00, 8'h07);
		rd(7'h01, 8'h01);
		wr(7'h06, 8'h15);
		u_host.frame(16'h007c, 8);
		chk1("soft_reset_instr", 1'b1, soft_reset_instr_n == 1);
		wait_busy(1'b0);
		rd(7'h00, 8'h04);
		rd(7'h06, 8'h2a);
		$display("test write cycle done");
		wr(7'h00, 8'h06);
		a0 = acc_n;
		rst_b_i <= 1'b0;
		fork
			u_host.frame(16'h007c, 8);
			begin
				// select is still low when reset lets go: no fall, so no instruction
				repeat (20) @(posedge clk_i);
				rst_b_i <= 1'b1;
			end
		join
		chk1("soft_reset_instr", 1'b1, soft_reset_instr_n == 1);
		chk1("accept", 1'b1, acc_n == a0);
		rd(7'h00, 8'h00, 8'h03);
		rd(7'h01, 8'h00, 8'h55);
		$display("test power reset done");
		give_verdict();
	end
endmodule : eeprom_reset_default_state_tb
